// ---- core/prcf_cfg.svh ----
// constants of the remote command framer: packet and operation codes, phy buffer, register map
// assumes nothing; included by the package and the modules
`ifndef PRCF_CFG_SVH
`define PRCF_CFG_SVH
`define PRCF_PKT_ID 2'h0
`define PRCF_TYPE_CMD 4'h8
`define PRCF_TYPE_CONF 4'hA
`define PRCF_CMD_FILL 8'h1C
`define PRCF_OP_NOP 3'h0
`define PRCF_OP_DISABLE 3'h1
`define PRCF_OP_SUSPEND 3'h2
`define PRCF_OP_CLRFAULT 3'h4
`define PRCF_OP_ENABLE 3'h5
`define PRCF_OP_RESUME 3'h6
`define PRCF_CONF_QUADS 14'h0002
`define PRCF_PHY_BUF 3'h6
`define PRCF_ADDR_CMD 4'h0
`define PRCF_ADDR_CTRL 4'h1
`define PRCF_ADDR_STAT 4'h2
`define PRCF_ADDR_TOKEN 4'h3
`define PRCF_ADDR_CONF 4'h4
`define PRCF_ADDR_RXCFG 4'h5
`endif

// ---- core/prcf_framer.sv ----
// remote command framer: sends command packets to the phy, takes confirmations
// assumes phy tx side handshakes with tx_ready; rx arrives as one quadlet pair pulse
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "prcf_cfg.svh"
module prcf_framer
  import prcf_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic tx_valid,
  output logic [31:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [31:0] rx_first,
  input wire logic [31:0] rx_second,
  input wire logic [4:0] rx_ack,
  input wire logic [1:0] rx_speed,
  input wire logic [1:0] rx_pad,
  output logic buf_wr,
  output logic [2:0] buf_sel,
  output logic [31:0] buf_data
);
  ////////////////////////////////////////////////////////////////////////////
  logic [5:0] node_phys_identifier_q;
  logic [2:0] page_q;
  logic [3:0] port_q;
  logic [2:0] remote_op_code_q;
  logic [2:0] phy_buf_q;
  logic busy;
  logic [2:0] sent_op_q;
  logic pending_q;
  logic conf_seen_q;
  logic mismatch_q;
  logic [31:0] token_q;
  logic [31:0] conf_q;
  logic [31:0] cmd_quad;
  logic [31:0] hold_quad_q;
  prcf_tx_state_t tx_state_q;
  logic is_conf;
  logic inverse_ok;
  logic [3:0] conf_port;
  logic [3:0] port_status;
  logic accepted;
  logic [2:0] echoed_op;
  logic wr_cmd;
  logic wr_ctrl;
  logic start;
  logic conf_take;
  logic [31:0] token_d;
  logic [1:0] buf_step_q;
  logic [31:0] conf_hold_q;
  logic clr_seen;
  logic wr_rxcfg;
  prcf_speed_t speed_code;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction : hit

  // status word: reported port and port bits above, local flags below
  function automatic logic [31:0] status_word(input logic [31:0] conf, input logic [3:0] flags);
    status_word = 32'h0000_0000;
    status_word[15:12] = conf[14:11];
    status_word[11:8] = conf[7:4];
    status_word[3:0] = flags;
  endfunction : status_word

  assign wr_cmd = reg_wr && hit(reg_addr, `PRCF_ADDR_CMD);
  assign wr_ctrl = reg_wr && hit(reg_addr, `PRCF_ADDR_CTRL);
  assign wr_rxcfg = reg_wr && hit(reg_addr, `PRCF_ADDR_RXCFG);
  assign clr_seen = wr_ctrl && reg_wdata[1];
  assign start = wr_ctrl && reg_wdata[0] && (tx_state_q == PRCF_TX_IDLE);
  // undefined speed code 11 is kept as received for software to judge
  assign speed_code = prcf_speed_t'(rx_speed);

  ////////////////////////////////////////////////////////////////////////////
  // command fields, held steady while a frame is out
  always_ff @(posedge clk) begin
    if (!resetn) begin
      node_phys_identifier_q <= 6'h00;
      page_q <= 3'h0;
      port_q <= 4'h0;
      remote_op_code_q <= `PRCF_OP_NOP;
    end else if (wr_cmd && (tx_state_q == PRCF_TX_IDLE)) begin
      node_phys_identifier_q <= reg_wdata[29:24];
      page_q <= reg_wdata[17:15];
      port_q <= reg_wdata[14:11];
      remote_op_code_q <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phy_buf_q <= `PRCF_PHY_BUF;
    end else if (wr_rxcfg) begin
      phy_buf_q <= reg_wdata[2:0];
    end
  end

  // the echo is matched against the code actually sent, not a later write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sent_op_q <= `PRCF_OP_NOP;
    end else if (start) begin
      sent_op_q <= remote_op_code_q;
    end
  end

  prcf_tx_builder u_builder (
    .node_phys_identifier(node_phys_identifier_q),
    .page(page_q),
    .port(port_q),
    .remote_op_code(remote_op_code_q),
    .quadlet(cmd_quad)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmit: first quadlet then its inverse
  // a start while a frame is out is dropped, not queued
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_state_q <= PRCF_TX_IDLE;
      hold_quad_q <= 32'h0000_0000;
    end else begin
      unique case (tx_state_q)
        PRCF_TX_IDLE: begin
          if (start) begin
            tx_state_q <= PRCF_TX_FIRST;
            hold_quad_q <= cmd_quad;
          end
        end
        PRCF_TX_FIRST: begin
          if (tx_ready) begin
            tx_state_q <= PRCF_TX_SECOND;
          end
        end
        PRCF_TX_SECOND: begin
          if (tx_ready) begin
            tx_state_q <= PRCF_TX_IDLE;
          end
        end
        default: begin
          tx_state_q <= PRCF_TX_IDLE;
        end
      endcase
    end
  end

  assign tx_valid = (tx_state_q != PRCF_TX_IDLE);
  assign tx_last = (tx_state_q == PRCF_TX_SECOND);
  assign tx_data = (tx_state_q == PRCF_TX_SECOND) ? ~hold_quad_q : hold_quad_q;
  assign busy = tx_valid;

  ////////////////////////////////////////////////////////////////////////////
  prcf_rx_parser u_parser (
    .first_q(rx_first),
    .second_q(rx_second),
    .is_conf(is_conf),
    .inverse_ok(inverse_ok),
    .conf_port(conf_port),
    .port_status(port_status),
    .accepted(accepted),
    .echoed_op(echoed_op)
  );

  assign conf_take = rx_valid && is_conf && inverse_ok;

  always_comb begin
    token_d = 32'h0000_0000;
    token_d[29:16] = `PRCF_CONF_QUADS;
    token_d[15] = 1'b0;
    token_d[14] = 1'b1;
    token_d[12:8] = rx_ack;
    token_d[7:6] = rx_pad;
    token_d[5:4] = speed_code;
  end

  // pending is set by a sent command, cleared by its answer; a new send wins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pending_q <= 1'b0;
    end else if (tx_state_q == PRCF_TX_SECOND && tx_ready) begin
      pending_q <= 1'b1;
    end else if (conf_take) begin
      pending_q <= 1'b0;
    end
  end

  // an arriving confirmation wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      conf_seen_q <= 1'b0;
      mismatch_q <= 1'b0;
    end else if (conf_take) begin
      conf_seen_q <= 1'b1;
      mismatch_q <= !pending_q || (echoed_op != sent_op_q);
    end else if (clr_seen) begin
      conf_seen_q <= 1'b0;
      mismatch_q <= 1'b0;
    end
  end

  // last token and confirmation kept for software
  always_ff @(posedge clk) begin
    if (!resetn) begin
      token_q <= 32'h0000_0000;
      conf_q <= 32'h0000_0000;
    end else if (conf_take) begin
      token_q <= token_d;
      conf_q <= rx_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // token then quadlet into the phy buffer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      buf_step_q <= 2'h0;
      buf_wr <= 1'b0;
    end else if (conf_take) begin
      buf_step_q <= 2'h1;
      buf_wr <= 1'b1;
    end else if (buf_step_q == 2'h1) begin
      buf_step_q <= 2'h0;
      buf_wr <= 1'b1;
    end else begin
      buf_wr <= 1'b0;
    end
  end

  // the token goes first so the host can size its read before the data
  always_ff @(posedge clk) begin
    if (!resetn) begin
      buf_sel <= `PRCF_PHY_BUF;
      buf_data <= 32'h0000_0000;
      conf_hold_q <= 32'h0000_0000;
    end else if (conf_take) begin
      buf_sel <= phy_buf_q;
      buf_data <= token_d;
      conf_hold_q <= rx_first;
    end else if (buf_step_q == 2'h1) begin
      buf_data <= conf_hold_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `PRCF_ADDR_CMD: reg_rdata <= cmd_quad;
        `PRCF_ADDR_STAT: begin
          reg_rdata <= status_word(conf_q, {mismatch_q, conf_seen_q, pending_q, busy});
        end
        `PRCF_ADDR_TOKEN: reg_rdata <= token_q;
        `PRCF_ADDR_CONF: reg_rdata <= conf_q;
        `PRCF_ADDR_RXCFG: reg_rdata <= {29'h0000_0000, phy_buf_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : prcf_framer

// ---- core/prcf_pkg.sv ----
// types of the remote command framer
// assumes the cfg header for the numbers
`include "prcf_cfg.svh"
package prcf_pkg;
  typedef enum logic [1:0] {
    PRCF_SPD_100,
    PRCF_SPD_200,
    PRCF_SPD_400,
    PRCF_SPD_UNDEF
  } prcf_speed_t;
  typedef enum logic [1:0] {
    PRCF_TX_IDLE,
    PRCF_TX_FIRST,
    PRCF_TX_SECOND
  } prcf_tx_state_t;
endpackage : prcf_pkg

// ---- core/prcf_rx_parser.sv ----
// decodes a received phy packet quadlet pair as a confirmation
// assumes both quadlets are presented together, same clock
`timescale 1ns/100ps
`include "prcf_cfg.svh"
module prcf_rx_parser
  import prcf_pkg::*;
(
  input wire logic [31:0] first_q,
  input wire logic [31:0] second_q,
  output logic is_conf,
  output logic inverse_ok,
  output logic [3:0] conf_port,
  output logic [3:0] port_status,
  output logic accepted,
  output logic [2:0] echoed_op
);
  always_comb begin
    is_conf = (first_q[31:30] == `PRCF_PKT_ID) && (first_q[21:18] == `PRCF_TYPE_CONF);
    inverse_ok = (second_q == ~first_q);
    conf_port = first_q[14:11];
    port_status = first_q[7:4];
    accepted = first_q[3];
    echoed_op = first_q[2:0];
  end
endmodule : prcf_rx_parser

// ---- core/prcf_tx_builder.sv ----
// builds the first quadlet of a remote command packet
// assumes inputs are held stable by the caller while framing
`timescale 1ns/100ps
`include "prcf_cfg.svh"
module prcf_tx_builder
  import prcf_pkg::*;
(
  input wire logic [5:0] node_phys_identifier,
  input wire logic [2:0] page,
  input wire logic [3:0] port,
  input wire logic [2:0] remote_op_code,
  output logic [31:0] quadlet
);
  always_comb begin
    quadlet = 32'h0000_0000;
    quadlet[31:30] = `PRCF_PKT_ID;
    quadlet[29:24] = node_phys_identifier;
    quadlet[21:18] = `PRCF_TYPE_CMD;
    quadlet[17:15] = page;
    quadlet[14:11] = port;
    quadlet[10:3] = `PRCF_CMD_FILL;
    quadlet[2:0] = remote_op_code;
  end
endmodule : prcf_tx_builder

// ---- verif/prcf_framer_assertions.sv ----
// port checker for the remote command framer
// assumes bind to prcf_framer, one clock domain
`timescale 1ns/100ps
module prcf_framer_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [31:0] rx_first,
  input wire logic [31:0] rx_second,
  input wire logic [4:0] rx_ack,
  input wire logic [1:0] rx_speed,
  input wire logic [1:0] rx_pad,
  input wire logic buf_wr,
  input wire logic [31:0] buf_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic conf_ok;
  assign conf_ok = rx_valid && rx_first[31:30] == 2'h0 && rx_first[21:18] == 4'hA
    && rx_second == ~rx_first;
  ////////////////////////////////////////
  a_hold_offer:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("offer dropped");
  a_frame_ends:
    assert property (tx_valid && tx_last && tx_ready |=> !tx_valid)
      else $error("frame too long");
  a_first_fields:
    assert property (tx_valid && !tx_last |-> tx_data[31:30] == 2'h0
      && tx_data[21:18] == 4'h8 && tx_data[10:3] == 8'h1C) else $error("bad first quadlet");
  a_second_inverse:
    assert property (tx_valid && tx_ready && !tx_last |=> tx_valid && tx_last
      && tx_data == ~$past(tx_data)) else $error("second not inverse");
  a_token_flags:
    assert property (conf_ok |=> buf_wr && buf_data[29:16] == 14'h0002
      && buf_data[15:14] == 2'h1 && buf_data[12:8] == $past(rx_ack)) else $error("bad token");
  a_token_speed:
    assert property (conf_ok |=> buf_data[7:4] == {$past(rx_pad), $past(rx_speed)})
      else $error("bad pad or speed");
  a_conf_stored:
    assert property (conf_ok ##1 1'b1 |=> buf_wr && buf_data == $past(rx_first, 2))
      else $error("confirmation not stored");
  a_bad_ignored:
    assert property (rx_valid && !conf_ok |=> !buf_wr) else $error("bad packet stored");
  c_conf: cover property (conf_ok);
  c_stall: cover property (tx_valid && !tx_ready);
  c_frame: cover property (tx_valid && tx_last && tx_ready);
endmodule : prcf_framer_assertions
bind prcf_framer prcf_framer_assertions chk (.clk(clk), .resetn(resetn), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
  .rx_first(rx_first), .rx_second(rx_second), .rx_ack(rx_ack), .rx_speed(rx_speed),
  .rx_pad(rx_pad), .buf_wr(buf_wr), .buf_data(buf_data));

// ---- verif/prcf_framer_test.sv ----
// self-checking bench for prcf_framer with the phy model on its link side
// assumes design files compiled first
`timescale 1ns/100ps
module prcf_framer_test;
  typedef struct packed {
    logic [5:0] node;
    logic [2:0] page;
    logic [3:0] port;
    logic [2:0] op;
    logic [1:0] spd;
    logic [1:0] pad;
    logic slow;
  } prcf_row_t;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0, corrupt = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [1:0] spd = 2'h0, pad = 2'h0, rx_speed, rx_pad;
  logic [4:0] ack = 5'h00, rx_ack;
  logic [31:0] reg_rdata, tx_data, rx_first, rx_second, buf_data, got_first, got_second;
  logic [31:0] val, q, hits;
  logic tx_valid, tx_last, tx_ready, rx_valid, buf_wr;
  logic [2:0] buf_sel;
  prcf_row_t r;
  int failures = 0, n_tests = 0, cycles = 0;
  prcf_row_t rows [6] = '{'{6'h01, 3'h0, 4'h0, 3'h0, 2'h0, 2'h0, 1'b0},
    '{6'h3F, 3'h7, 4'hF, 3'h1, 2'h1, 2'h3, 1'b1}, '{6'h12, 3'h2, 4'h3, 3'h2, 2'h2, 2'h1, 1'b0},
    '{6'h2A, 3'h5, 4'hA, 3'h4, 2'h0, 2'h2, 1'b1}, '{6'h05, 3'h1, 4'h7, 3'h5, 2'h1, 2'h0, 1'b0},
    '{6'h20, 3'h6, 4'h1, 3'h6, 2'h2, 2'h3, 1'b1}};
  prcf_framer dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_first(rx_first), .rx_second(rx_second), .rx_ack(rx_ack), .rx_speed(rx_speed),
    .rx_pad(rx_pad), .buf_wr(buf_wr), .buf_sel(buf_sel), .buf_data(buf_data));
  prcf_phy_model phy (.clk(clk), .slow(slow), .corrupt(corrupt), .ack(ack), .speed(spd),
    .pad(pad), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_first(rx_first), .rx_second(rx_second), .rx_ack(rx_ack),
    .rx_speed(rx_speed), .rx_pad(rx_pad), .got_first(got_first), .got_second(got_second));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////
  task end_of_test;
    $display("%0d checks, %0d failures", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 val = reg_rdata;
  endtask : rd
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(4'h5); chk(val, 32'h6);
    rd(4'hF); chk(val, 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      {slow, spd, pad, ack} <= {r.slow, r.spd, r.pad, i[4:0] + 5'h3};
      q = {2'h0, r.node, 2'h0, 4'h8, r.page, r.port, 8'h1C, r.op};
      wr(4'h0, q);
      rd(4'h0); chk(val, q);
      wr(4'h1, 32'h1);
      #1;
      for (int k = 0; k < 40 && buf_wr !== 1'b1; k++) @(posedge clk) #1;
      chk({31'h0, buf_wr}, 32'h1);
      chk({29'h0, buf_sel}, 32'h6);
      chk(buf_data, {2'h0, 14'h0002, 3'h2, ack, pad, spd, 4'h0});
      @(posedge clk) #1;
      chk(buf_data, {2'h0, r.node, 6'h0A, 3'h0, r.port, 3'h0, r.port ^ 4'h5, 1'b1, r.op});
      chk(got_first, q);
      chk(got_second, ~q);
      rd(4'h2);
      chk({val[15:8], val[3:2], val[0]}, {r.port, r.port ^ 4'h5, 3'h2});
      rd(4'h3); chk(val, {2'h0, 14'h0002, 3'h2, ack, pad, spd, 4'h0});
      rd(4'h4); chk(val[14:0], {r.port, 3'h0, r.port ^ 4'h5, 1'b1, r.op});
      wr(4'h1, 32'h2);
      $display("test %0d done", i);
    end
    corrupt <= 1'b1;
    hits = 32'h0;
    wr(4'h1, 32'h1);
    repeat (20) @(posedge clk) #1 hits = hits + {31'h0, buf_wr};
    chk(hits, 32'h0);
    rd(4'h2); chk({30'h0, val[3:2]}, 32'h0);
    corrupt <= 1'b0;
    $display("test bad inverse done");
    wr(4'h5, 32'h3);
    rd(4'h5); chk(val, 32'h3);
    slow <= 1'b0;
    wr(4'h1, 32'h1);
    repeat (2) @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    rd(4'h5); chk(val, 32'h6);
    chk({31'h0, tx_valid}, 32'h0);
    repeat (6) @(posedge clk);
    rd(4'h2); chk({28'h0, val[3:0]}, 32'hC);
    $display("test reset done");
    end_of_test();
  end
endmodule : prcf_framer_test

// ---- verif/prcf_phy_model.sv ----
// phy and remote node model: takes command frames, answers with a confirmation
// assumes the bench sets stall, corruption and receive status
`timescale 1ns/100ps
module prcf_phy_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic corrupt,
  input wire logic [4:0] ack,
  input wire logic [1:0] speed,
  input wire logic [1:0] pad,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic rx_valid,
  output logic [31:0] rx_first,
  output logic [31:0] rx_second,
  output logic [4:0] rx_ack,
  output logic [1:0] rx_speed,
  output logic [1:0] rx_pad,
  output logic [31:0] got_first,
  output logic [31:0] got_second
);
  logic [2:0] wait_q = 3'h0;
  logic [31:0] conf;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    {rx_first, rx_second, rx_ack, rx_speed, rx_pad} = '0;
  end
  assign conf = {2'h0, got_first[29:24], 2'h0, 4'hA, 3'h0, got_first[14:11], 3'h0,
    got_first[14:11] ^ 4'h5, 1'b1, got_first[2:0]};
  always @(posedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    rx_valid <= 1'b0;
    // released lines flip each cycle; the stale pair stays inverse and looks valid again every second cycle
    {rx_first, rx_second, rx_ack, rx_speed, rx_pad} <= ~{rx_first, rx_second, rx_ack,
      rx_speed, rx_pad};
    if (tx_valid && tx_ready && !tx_last) got_first <= tx_data;
    if (tx_valid && tx_ready && tx_last) begin
      got_second <= tx_data;
      wait_q <= 3'h4;
    end else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
    if (wait_q == 3'h1) begin
      rx_valid <= 1'b1;
      rx_first <= conf;
      rx_second <= corrupt ? conf : ~conf;
      {rx_ack, rx_speed, rx_pad} <= {ack, speed, pad};
    end
  end
endmodule : prcf_phy_model
